// File: logic/fec_counters.v
/*
  Receive framing error counters: out-of-sync count and far-end block
  error count, latched into byte-wide read registers on each update.
  Assumes framer status inputs are synchronous one-cycle pulses or
  levels in the clk domain; host reads by a plain address and strobe.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fec_defs.vh"

// Summary of operation
// - T1: count out-of-sync multiframes, even during sync loss
// - T1 alternate: count F-bit pattern errors
// - T1 F-bit counting paused during sync loss
// - Framing mode and count select choose source
// - E1: count each bad alignment word
// - E1: hold counter while sync lost
// - E1: no counting while searching alignment
// - E1 counter needs no saturation
// - Out-of-sync count: high byte, low byte
// - Far-end error counter only in E1
// - E-bits from frames 13, 15 of multiframe
// - Count each received E-bit equal zero
// - Pause E-bit count on FAS/CRC-4 loss
// - Keep E-bit count on CAS loss only
// - E-bit counter needs no saturation
// - Far-end count as two bytes, reset zero
// - Latch counts every second or short interval
// - Manual update rising edge latches and clears
module fec_counters #(
  parameter UPD_1S_CYC = `FEC_UPD_1S_CYC,
  parameter UPD_T1_CYC = `FEC_UPD_T1_CYC,
  parameter UPD_E1_CYC = `FEC_UPD_E1_CYC
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire e1_mode,
  input wire esf_mode,
  input wire count_fbit_errors,
  input wire count_update_interval_select,
  input wire manual_update_enable,
  input wire manual_count_update,
  input wire receive_sync_lost,
  input wire multiframe_unsynced,
  input wire ft_error,
  input wire fps_error,
  input wire fas_word_error,
  input wire fas_searching,
  input wire cas_searching,
  input wire crc4_searching,
  input wire crc4_sync_lost,
  input wire ebit_valid,
  input wire ebit_value,
  input wire [7:0] reg_addr,
  input wire reg_rd,
  output reg [7:0] reg_rdata_r,
  output reg update_pulse_r
);
  reg [`FEC_TMR_W-1:0] tmr_r;
  reg [`FEC_TMR_W-1:0] tmr_nxt;
  reg [`FEC_TMR_W-1:0] tmr_limit;
  reg manual_prev_r;
  reg [15:0] oos_latched_r;
  reg [15:0] fee_latched_r;
  reg oos_event;
  reg fee_event;
  wire tmr_done;
  wire manual_edge;
  wire update_now;
  wire [15:0] oos_count;
  wire [15:0] fee_count;

  // Interval choice; the timer is idle while manual update owns the latch
  always @* begin
    if (count_update_interval_select) begin
      tmr_limit = e1_mode ? UPD_E1_CYC[`FEC_TMR_W-1:0] : UPD_T1_CYC[`FEC_TMR_W-1:0];
    end else begin
      tmr_limit = UPD_1S_CYC[`FEC_TMR_W-1:0];
    end
  end

  assign tmr_done = (tmr_r >= tmr_limit - {{(`FEC_TMR_W-1){1'b0}}, 1'b1});
  assign manual_edge = manual_update_enable && manual_count_update && !manual_prev_r;
  assign update_now = manual_update_enable ? manual_edge : tmr_done;

  always @* begin
    tmr_nxt = tmr_r + {{(`FEC_TMR_W-1){1'b0}}, 1'b1};
    if (manual_update_enable || tmr_done) begin
      tmr_nxt = {`FEC_TMR_W{1'b0}};
    end
  end

  // Event source selection for the out-of-sync counter
  always @* begin
    oos_event = 1'b0;
    if (e1_mode) begin
      // Disabled on sync loss and during any alignment search
      oos_event = fas_word_error && !receive_sync_lost &&
                  !fas_searching && !cas_searching && !crc4_searching;
    end else if (count_fbit_errors) begin
      oos_event = (esf_mode ? fps_error : ft_error) && !receive_sync_lost;
    end else begin
      // Sync loss does not stop multiframe counting
      oos_event = multiframe_unsynced;
    end
  end

  // CAS search deliberately not in this gate
  always @* begin
    fee_event = e1_mode && ebit_valid && !ebit_value &&
                !receive_sync_lost && !fas_searching && !crc4_sync_lost;
  end

  // No saturation: worst case per period is far below 16 bits
  fec_event_counter #(.W(16)) u_oos (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .clear(update_now),
    .event_in(oos_event),
    .count_r(oos_count)
  );

  fec_event_counter #(.W(16)) u_fee (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .clear(update_now),
    .event_in(fee_event),
    .count_r(fee_count)
  );

  always @(posedge clk) begin
    if (rst) begin
      tmr_r <= {`FEC_TMR_W{1'b0}};
      manual_prev_r <= 1'b0;
      oos_latched_r <= `FEC_CNT_RESET;
      fee_latched_r <= `FEC_CNT_RESET;
      update_pulse_r <= 1'b0;
    end else if (ce) begin
      tmr_r <= tmr_nxt;
      manual_prev_r <= manual_count_update;
      update_pulse_r <= update_now;
      if (update_now) begin
        // Both halves change in one cycle only, so paired reads agree
        oos_latched_r <= oos_count;
        fee_latched_r <= fee_count;
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      reg_rdata_r <= `FEC_READ_UNMAPPED;
    end else if (ce) begin
      if (reg_rd) begin
        case (reg_addr)
          `FEC_OFS_OOS_HIGH: reg_rdata_r <= oos_latched_r[15:8];
          `FEC_OFS_OOS_LOW: reg_rdata_r <= oos_latched_r[7:0];
          `FEC_OFS_FEE_HIGH: reg_rdata_r <= fee_latched_r[15:8];
          `FEC_OFS_FEE_LOW: reg_rdata_r <= fee_latched_r[7:0];
          default: reg_rdata_r <= `FEC_READ_UNMAPPED;
        endcase
      end
    end
  end
endmodule // fec_counters
`default_nettype wire

// File: logic/fec_defs.vh
/*
  Constants for the receive framing error counters: register offsets,
  reset values and update interval counts.
  Assumes inclusion by bare name from the logic folder.
*/
`ifndef FEC_DEFS_VH
`define FEC_DEFS_VH

`define FEC_OFS_OOS_HIGH 8'h46
`define FEC_OFS_OOS_LOW 8'h47
`define FEC_OFS_FEE_HIGH 8'h48
`define FEC_OFS_FEE_LOW 8'h49
`define FEC_CNT_RESET 16'h0000
`define FEC_READ_UNMAPPED 8'h00
`define FEC_CLK_HZ 50000000
`define FEC_UPD_1S_MS 1000
`define FEC_UPD_T1_US 42000
`define FEC_UPD_E1_US 62500
`define FEC_UPD_1S_CYC (`FEC_CLK_HZ / 1000 * `FEC_UPD_1S_MS)
`define FEC_UPD_T1_CYC (`FEC_CLK_HZ / 1000000 * `FEC_UPD_T1_US)
`define FEC_UPD_E1_CYC (`FEC_CLK_HZ / 1000000 * `FEC_UPD_E1_US)
`define FEC_TMR_W 26

`endif

// File: logic/fec_event_counter.v
/*
  One 16-bit event counter with clear-on-update and an enable.
  Assumes the caller gates events; count wraps, since the caller's
  accumulation period keeps it far from the top.
*/
`timescale 1ns/10ps
`default_nettype none
module fec_event_counter #(
  parameter W = 16
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire clear,
  input wire event_in,
  output reg [W-1:0] count_r
);
  reg [W-1:0] count_nxt;

  always @* begin
    count_nxt = count_r;
    if (clear) begin
      // An event in the update cycle starts the next period
      count_nxt = event_in ? {{(W-1){1'b0}}, 1'b1} : {W{1'b0}};
    end else if (event_in) begin
      count_nxt = count_r + {{(W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      count_r <= {W{1'b0}};
    end else if (ce) begin
      count_r <= count_nxt;
    end
  end
endmodule // fec_event_counter
`default_nettype wire

// File: tb/fec_checker.sv
/* Port checker for fec_counters: read answers, update pulses and clock-enable freeze; bound below. */
`timescale 1ns/10ps
`default_nettype none
module fec_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic manual_update_enable,
  input wire logic manual_count_update,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_r,
  input wire logic update_pulse_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_edge; manual_update_enable && $rose(manual_count_update); endsequence
  sequence s_reread; reg_rd ##1 reg_rd && $stable(reg_addr) && !update_pulse_r; endsequence
  a_unmapped_zero: assert property (reg_rd && (reg_addr < 8'h46 || reg_addr > 8'h49) |=> !reg_rdata_r)
    else $error("unmapped read");
  a_edge_pulse: assert property (s_edge |=> update_pulse_r) else $error("no pulse");
  a_no_timer: assert property (manual_update_enable && !$rose(manual_count_update) |=> !update_pulse_r)
    else $error("stray pulse");
  a_pulse_cause: assert property (update_pulse_r && $past(manual_update_enable) |->
    $past(manual_count_update) && !$past(manual_count_update, 2)) else $error("pulse cause");
  a_read_holds: assert property (!reg_rd |=> $stable(reg_rdata_r)) else $error("data moved");
  a_reread_same: assert property (s_reread |=> reg_rdata_r == $past(reg_rdata_r)) else $error("reread");
  a_pulse_single: assert property (update_pulse_r |=> !update_pulse_r) else $error("long pulse");
  a_freeze_hold: assert property (!ce |=> $stable(reg_rdata_r) && $stable(update_pulse_r))
    else $error("moved while frozen");
  a_reset_clear: assert property (disable iff (1'b0) rst |=> !reg_rdata_r && !update_pulse_r)
    else $error("reset values");
endmodule // fec_checker
bind fec_counters fec_checker fec_checker_i (.*);
`default_nettype wire

// File: tb/fec_framer_model.sv
/* Framer status model: error pulses and E-bits; assumes rnd changes at the falling edge. */
`timescale 1ns/10ps
`default_nettype none
module fec_framer_model (
  input wire logic [7:0] rnd,
  output logic [5:0] ev
);
  // Bit 7 gates the errors so quiet spells occur; the E-bit valid and value bits are not gated by it
  assign ev = {rnd[3:0] & {4{rnd[7]}}, rnd[4], rnd[5] ^ rnd[6]};
endmodule // fec_framer_model
`default_nettype wire

// File: tb/test_fec_counters.sv
/* Bench for fec_counters: random framer traffic, manual and timed updates; assumes the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module test_fec_counters;
  logic clk = 0, rst = 1, ce = 1, e1 = 0, esf = 0, fb = 0, sel = 0, men = 1, mcu = 0, rd = 0, up;
  logic [4:0] lv = 0;
  logic [5:0] ev;
  logic [7:0] a = 0, r = 0, lf = 8'h3f, q;
  logic [15:0] xo = 0, xe = 0;
  integer failures = 0, total_checks = 0, t, n;
  fec_counters #(40, 20, 30) fec_counters_i (.clk, .rst, .ce, .e1_mode(e1), .esf_mode(esf), .count_fbit_errors(fb),
    .count_update_interval_select(sel), .manual_update_enable(men), .manual_count_update(mcu),
    .receive_sync_lost(lv[4]), .fas_searching(lv[3]), .cas_searching(lv[2]), .crc4_searching(lv[1]),
    .crc4_sync_lost(lv[0]), .multiframe_unsynced(ev[5]), .ft_error(ev[4]), .fps_error(ev[3]),
    .fas_word_error(ev[2]), .ebit_valid(ev[1]), .ebit_value(ev[0]), .reg_addr(a), .reg_rd(rd),
    .reg_rdata_r(q), .update_pulse_r(up));
  fec_framer_model fec_framer_model_i (.rnd(r), .ev);
  initial forever #10 clk = ~clk;
  function [7:0] nx(input [7:0] s);
    nx = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function fo();
    fo = e1 ? ev[2] & ~|lv[4:1] : fb ? ~lv[4] & (esf ? ev[3] : ev[4]) : ev[5];
  endfunction
  function fe();
    fe = e1 & ev[1] & ~ev[0] & ~lv[4] & ~lv[3] & ~lv[0];
  endfunction
  always @(posedge clk) begin
    if (ce) begin
      xo <= xo + 16'(fo());
      xe <= xe + 16'(fe());
    end
  end
  task ck(input string s, input [15:0] e, input [15:0] g);
    total_checks++;
    if (e !== g) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  // Read strobe stays high between calls, so reads run back to back
  task rc(input [7:0] ad, input [7:0] e);
    a = ad;
    rd = 1;
    @(negedge clk);
    ck("read data", 16'(e), 16'(q));
  endtask
  task ra(input [15:0] o, input [15:0] e);
    rc(8'h46, o[15:8]);
    rc(8'h46, o[15:8]);
    rc(8'h47, o[7:0]);
    rc(8'h48, e[15:8]);
    rc(8'h49, e[7:0]);
    rc(8'h4a, 8'h00);
    rd = 0;
  endtask
  task wp;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (up !== 1'b1 && n < 200);
  endtask
  task print_verdict;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    print_verdict;
  end
  initial begin
    repeat (4) @(negedge clk);
    rst = 0;
    ra(0, 0);
    for (t = 0; t < 27; t++) begin
      if (t < 24) begin
        {e1, esf, fb} = lf[2:0];
        lv = t < 4 ? 5'h0 : lf[7:3] & lf[4:0];
        repeat (30) begin
          @(negedge clk);
          lf = nx(lf);
          r = lf;
          ce = lf[6] | lf[1];
        end
        r = 0;
        ce = 1;
        repeat (2) @(negedge clk);
        mcu = 1;
        @(negedge clk);
        mcu = 0;
        @(negedge clk);
        ra(xo, xe);
        // Cleared late: traffic is quiet from the latch until here
        {xo, xe} = 0;
      end else begin
        men = 0;
        {e1, sel} = {t == 26, t > 24};
        repeat (3) wp;
        ck("update gap", t == 24 ? 40 : t == 25 ? 20 : 30, n[15:0]);
      end
      $display("test %0d done", t);
    end
    print_verdict;
  end
endmodule // test_fec_counters
`default_nettype wire
